// ### pkg/mem_if_pkg.sv
// constants for the external memory bus interface
package mem_if_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CLK_DIV_W = 4;
  // processor clock divider: half period in clk cycles (speed grade dependent)
  localparam logic [CLK_DIV_W-1:0] PCLK_HALF_DEFAULT = 4'h2;
  localparam logic [CLK_DIV_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CLK_DIV_W-1:0] CNT_ONE = 4'h1;
  localparam int unsigned BOOT_W = 8;
  // cycles spent initialising after reset before the bootstrap is started
  localparam logic [BOOT_W-1:0] BOOT_INIT_CYCLES = 8'h10;
  localparam logic [BOOT_W-1:0] BOOT_ZERO = 8'h00;
  localparam logic [BOOT_W-1:0] BOOT_ONE = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
  localparam logic [1:0] STROBE_IDLE = 2'h3;
  localparam logic [1:0] STROBE_NONE = 2'h0;
  localparam logic [1:0] LANE_LOW = 2'h1;
  localparam logic [1:0] LANE_HIGH = 2'h2;
  localparam logic [1:0] LANE_BOTH = 2'h3;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_STROBE,
    ST_DONE,
    ST_GRANT,
    ST_RELEASE
  } mem_state_e;
endpackage : mem_if_pkg

// ### hw/proc_clock_gen.sv
// processor clock divider running in step with the interface
`timescale 1ns/1ps
module proc_clock_gen
  import mem_if_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire logic [CLK_DIV_W-1:0] half_period,
  output logic                      pclk_q,
  output logic                      pclk_rise_q
);
  logic [CLK_DIV_W-1:0] cnt_q;
  logic [CLK_DIV_W-1:0] cnt_d;
  logic                 pclk_d;
  logic                 rise_d;

  always_comb
  begin
    cnt_d  = cnt_q + CNT_ONE;
    pclk_d = pclk_q;
    rise_d = 1'b0;
    if (cnt_q >= half_period - CNT_ONE)
    begin
      cnt_d  = CNT_ZERO;
      pclk_d = ~pclk_q;
      rise_d = ~pclk_q;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_q       <= CNT_ZERO;
      pclk_q      <= 1'b0;
      pclk_rise_q <= 1'b0;
    end
    else
    begin
      cnt_q       <= cnt_d;
      pclk_q      <= pclk_d;
      pclk_rise_q <= rise_d;
    end
  end
endmodule : proc_clock_gen

// ### hw/external_memory_bus_interface.sv
// external memory bus interface: word/byte cycles, wait stretch, bus handover
`timescale 1ns/1ps
module external_memory_bus_interface
  import mem_if_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              proc_req,
  input  wire logic              proc_write,
  input  wire logic [ADDR_W-1:0] proc_addr,
  input  wire logic [DATA_W-1:0] proc_wdata,
  output logic                   proc_done_q,
  output logic      [DATA_W-1:0] proc_rdata_q,
  output logic                   bootstrap_start_q,
  output logic      [ADDR_W-1:0] mem_address_bus_q,
  output logic                   mem_address_bus_oe_q,
  input  wire logic [DATA_W-1:0] mem_data_bus_i,
  output logic      [DATA_W-1:0] mem_data_bus_o_q,
  output logic                   mem_data_bus_oe_q,
  input  wire logic              byte_access_select,
  input  wire logic              external_bus_request,
  output logic                   external_bus_grant_q,
  input  wire logic              cycle_stretch_input,
  output logic                   chip_enable_n_q,
  output logic      [1:0]        byte_write_strobe_n_q,
  output logic                   processor_clock_output_q
);
  mem_state_e        state_q, state_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] wdata_q, wdata_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic              wr_q, wr_d;
  logic              byte_q, byte_d;
  logic              aoe_q, aoe_d;
  logic              doe_q, doe_d;
  logic              grant_q, grant_d;
  logic              ce_n_q, ce_n_d;
  logic [1:0]        wstb_n_q, wstb_n_d;
  logic              done_q, done_d;
  logic [BOOT_W-1:0] boot_cnt_q, boot_cnt_d;
  logic              boot_q, boot_d;
  logic              ready;
  logic              pclk;
  logic [1:0]        lanes;

  proc_clock_gen u_pclk (
    .clk         (clk),
    .resetn      (resetn),
    .half_period (PCLK_HALF_DEFAULT),
    .pclk_q      (pclk),
    .pclk_rise_q ()
  );

  // initialise for a fixed count after reset, then flag bootstrap start once
  always_comb
  begin
    boot_cnt_d = boot_cnt_q;
    boot_d     = 1'b0;
    if (boot_cnt_q != BOOT_INIT_CYCLES)
    begin
      boot_cnt_d = boot_cnt_q + BOOT_ONE;
      boot_d     = (boot_cnt_q == BOOT_INIT_CYCLES - BOOT_ONE);
    end
  end
  assign ready = (boot_cnt_q == BOOT_INIT_CYCLES);

  // byte lane picked by address bit 0 during byte access
  assign lanes = !byte_q ? LANE_BOTH : (addr_q[0] ? LANE_HIGH : LANE_LOW);

  always_comb
  begin
    state_d  = state_q;
    addr_d   = addr_q;
    wdata_d  = wdata_q;
    rdata_d  = rdata_q;
    wr_d     = wr_q;
    byte_d   = byte_q;
    aoe_d    = aoe_q;
    doe_d    = doe_q;
    grant_d  = grant_q;
    ce_n_d   = ce_n_q;
    wstb_n_d = wstb_n_q;
    done_d   = 1'b0;
    case (state_q)
      ST_IDLE:
      begin
        ce_n_d   = 1'b1;
        wstb_n_d = STROBE_IDLE;
        doe_d    = 1'b0;
        if (!ready)
        begin
          state_d = ST_IDLE;
        end
        else if (proc_req)
        begin
          // processor request wins; a bus request waits for it to finish
          addr_d  = proc_addr;
          wdata_d = proc_wdata;
          wr_d    = proc_write;
          byte_d  = byte_access_select;
          aoe_d   = 1'b1;
          state_d = ST_ADDR;
        end
        else if (external_bus_request)
        begin
          aoe_d   = 1'b0;
          doe_d   = 1'b0;
          grant_d = 1'b1;
          state_d = ST_GRANT;
        end
      end
      ST_ADDR:
      begin
        ce_n_d  = 1'b0;
        doe_d   = wr_q;
        state_d = ST_STROBE;
      end
      ST_STROBE:
      begin
        if (wr_q)
        begin
          wstb_n_d = ~lanes;
        end
        if (!cycle_stretch_input)
        begin
          state_d = ST_DONE;
        end
      end
      ST_DONE:
      begin
        if (!wr_q)
        begin
          rdata_d = mem_data_bus_i;
        end
        wstb_n_d = STROBE_IDLE;
        ce_n_d   = 1'b1;
        done_d   = 1'b1;
        state_d  = ST_IDLE;
      end
      ST_GRANT:
      begin
        // the requester drives only while grant is high
        if (!external_bus_request)
        begin
          grant_d = 1'b0;
          state_d = ST_RELEASE;
        end
      end
      ST_RELEASE:
      begin
        aoe_d   = 1'b1;
        state_d = ST_IDLE;
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q    <= ST_IDLE;
      addr_q     <= ADDR_RESET;
      wdata_q    <= DATA_RESET;
      rdata_q    <= DATA_RESET;
      wr_q       <= 1'b0;
      byte_q     <= 1'b0;
      aoe_q      <= 1'b1;
      doe_q      <= 1'b0;
      grant_q    <= 1'b0;
      ce_n_q     <= 1'b1;
      wstb_n_q   <= STROBE_IDLE;
      done_q     <= 1'b0;
      boot_cnt_q <= BOOT_ZERO;
      boot_q     <= 1'b0;
    end
    else
    begin
      state_q    <= state_d;
      addr_q     <= addr_d;
      wdata_q    <= wdata_d;
      rdata_q    <= rdata_d;
      wr_q       <= wr_d;
      byte_q     <= byte_d;
      aoe_q      <= aoe_d;
      doe_q      <= doe_d;
      grant_q    <= grant_d;
      ce_n_q     <= ce_n_d;
      wstb_n_q   <= wstb_n_d;
      done_q     <= done_d;
      boot_cnt_q <= boot_cnt_d;
      boot_q     <= boot_d;
    end
  end

  // outputs are plain copies of registers
  always_comb
  begin
    mem_address_bus_q        = addr_q;
    mem_address_bus_oe_q     = aoe_q;
    mem_data_bus_o_q         = wdata_q;
    mem_data_bus_oe_q        = doe_q;
    external_bus_grant_q     = grant_q;
    chip_enable_n_q          = ce_n_q;
    byte_write_strobe_n_q    = wstb_n_q;
    proc_done_q              = done_q;
    proc_rdata_q             = rdata_q;
    bootstrap_start_q        = boot_q;
    processor_clock_output_q = pclk;
  end
  // rise strobe left open: interface cycles count clk edges, not processor clock edges
endmodule : external_memory_bus_interface

// ### dv/mem_if_sva.sv
// bus protocol checker for the memory interface
`timescale 1ns/1ps
module mem_if_sva
(
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       mem_address_bus_oe_q,
  input wire logic       mem_data_bus_oe_q,
  input wire logic       external_bus_request,
  input wire logic       external_bus_grant_q,
  input wire logic       cycle_stretch_input,
  input wire logic       proc_done_q,
  input wire logic       chip_enable_n_q,
  input wire logic [1:0] byte_write_strobe_n_q,
  input wire logic       processor_clock_output_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence pclk_half_hi;
    processor_clock_output_q [*2] ##1 !processor_clock_output_q;
  endsequence
  sequence aoe_back;
    !mem_address_bus_oe_q ##1 mem_address_bus_oe_q;
  endsequence
  AST_FLOAT: assert property (external_bus_grant_q |-> !mem_address_bus_oe_q && !mem_data_bus_oe_q)
    else $error("bus driven while granted");
  AST_GRANT_DROP: assert property (external_bus_grant_q && !external_bus_request |=> !external_bus_grant_q)
    else $error("grant held after request dropped");
  AST_RESUME: assert property ($fell(external_bus_grant_q) |-> aoe_back)
    else $error("address drive not resumed after grant");
  AST_CE_ADDR: assert property (!chip_enable_n_q |-> mem_address_bus_oe_q)
    else $error("chip enable without address");
  AST_STROBE: assert property (byte_write_strobe_n_q != 2'h3 |-> !chip_enable_n_q && mem_data_bus_oe_q)
    else $error("strobe outside write cycle");
  // stretch is looked at only in the strobe phase; done follows the low sample by two edges
  AST_STRETCH: assert property (proc_done_q |-> !$past(cycle_stretch_input, 2))
    else $error("cycle ended while stretched");
  AST_STRETCH_HOLD: assert property ($fell(chip_enable_n_q) && cycle_stretch_input |-> ##2 !chip_enable_n_q)
    else $error("stretched cycle not held");
  AST_DONE: assert property (proc_done_q |-> chip_enable_n_q && !$past(chip_enable_n_q))
    else $error("done without memory cycle");
  AST_PCLK: assert property ($rose(processor_clock_output_q) |-> pclk_half_hi)
    else $error("processor clock half period wrong");
endmodule : mem_if_sva
bind external_memory_bus_interface mem_if_sva u_sva (.clk, .resetn, .mem_address_bus_oe_q, .mem_data_bus_oe_q,
  .external_bus_request, .external_bus_grant_q, .cycle_stretch_input, .proc_done_q, .chip_enable_n_q,
  .byte_write_strobe_n_q, .processor_clock_output_q);

// ### dv/mem_model.sv
// external memory model on the far side of the bus
`timescale 1ns/1ps
module mem_model
(
  input  wire logic        clk,
  input  wire logic        ce_n,
  input  wire logic [1:0]  wr_n,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic        doe,
  output logic      [15:0] rdata
);
  logic [15:0] mem [0:7];
  logic [15:0] last = 16'h0000;
  always @(posedge clk)
  begin
    if (!ce_n && !wr_n[0]) mem[addr[3:1]][7:0] <= wdata[7:0];
    if (!ce_n && !wr_n[1]) mem[addr[3:1]][15:8] <= wdata[15:8];
    last <= rdata;
  end
  // released bus toggles so a stale value can never pass for read data
  assign rdata = (!ce_n && !doe) ? mem[addr[3:1]] : ~last;
endmodule : mem_model

// ### dv/tb_top.sv
// self-checking bench for the external memory bus interface
`timescale 1ns/1ps
module tb_top
  import mem_if_pkg::*;
;
  logic clk = 1'b0, resetn = 1'b0, proc_req = 1'b0, proc_write = 1'b0, byte_access_select = 1'b0;
  logic external_bus_request = 1'b0, cycle_stretch_input = 1'b0, st_en = 1'b0, b;
  logic [15:0] proc_addr = 16'h0000, proc_wdata = 16'h0000, proc_rdata_q, mem_address_bus_q, mem_data_bus_o_q, mem_rd;
  logic proc_done_q, bootstrap_start_q, mem_address_bus_oe_q, mem_data_bus_oe_q, external_bus_grant_q;
  logic chip_enable_n_q, processor_clock_output_q;
  logic [1:0] byte_write_strobe_n_q;
  wire logic [15:0] mem_data_bus_i;
  logic [15:0] model [0:7];
  logic [31:0] v;
  int failures = 0, compares = 0, n, i;
  always #4 clk = ~clk;
  always @(negedge clk) cycle_stretch_input <= st_en ? 1'($urandom % 2) : 1'b0;
  assign mem_data_bus_i = mem_data_bus_oe_q ? mem_data_bus_o_q : mem_rd;
  external_memory_bus_interface dut (.*);
  mem_model mem (.clk, .ce_n(chip_enable_n_q), .wr_n(byte_write_strobe_n_q), .addr(mem_address_bus_q),
    .wdata(mem_data_bus_i), .doe(mem_data_bus_oe_q), .rdata(mem_rd));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : check
  task automatic final_report;
    if (failures == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d, input logic bs);
    int t;
    logic [15:0] e;
    @(negedge clk);
    {proc_req, proc_write, proc_addr, proc_wdata, byte_access_select} = {1'b1, w, a, d, bs};
    t = 0;
    do @(negedge clk); while (proc_done_q !== 1'b1 && ++t < 300);
    proc_req = 1'b0;
    check(16'(proc_done_q), 16'h0001, "access not done");
    e = model[a[3:1]];
    if (w)
    begin
      if (!bs || !a[0]) e[7:0] = d[7:0];
      if (!bs || a[0]) e[15:8] = d[15:8];
      model[a[3:1]] = e;
    end
    else if (bs) check(16'(a[0] ? proc_rdata_q[15:8] : proc_rdata_q[7:0]), 16'(a[0] ? e[15:8] : e[7:0]), "byte read");
    else check(proc_rdata_q, e, "word read");
  endtask : access
  initial
  begin
    #200000;
    failures++;
    final_report();
  end
  initial
  begin
    void'($urandom(32'h353b7215));
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    n = 0;
    while (bootstrap_start_q !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    check(16'(n), 16'h0010, "bootstrap timing");
    for (i = 0; i < 8; i++) access(1'b1, 16'(2 * i), 16'($urandom), 1'b0);
    st_en = 1'b1;
    for (i = 0; i < 80; i++)
    begin
      v = $urandom;
      b = v[16];
      access(v[17], {12'h000, v[20:18], b & v[21]}, b ? {2{v[7:0]}} : v[15:0], b);
    end
    @(negedge clk);
    external_bus_request = 1'b1;
    repeat (3) @(negedge clk);
    check(16'({external_bus_grant_q, mem_address_bus_oe_q, mem_data_bus_oe_q}), 16'h0004, "no grant");
    proc_req = 1'b1;
    proc_write = 1'b0;
    repeat (6) @(negedge clk);
    check(16'({proc_done_q, external_bus_grant_q}), 16'h0001, "taken while granted");
    external_bus_request = 1'b0;
    proc_req = 1'b0;
    access(1'b0, 16'h0006, 16'h0000, 1'b0);
    final_report();
  end
endmodule : tb_top
